// File: verilog/pm_pkg.sv
// Constants, field positions and types of the power management registers.
`default_nettype none
package pm_pkg;

    // Configuration dword addresses holding the two registers.
    localparam logic [7:0] CAP_DW_ADDR   = 8'ha0;
    localparam logic [7:0] CTRL_DW_ADDR  = 8'ha4;
    localparam logic [1:0] ADDR_LSB_ZERO = 2'h0;

    // Byte lane and bit position of the capabilities word in its dword.
    localparam int CAP_LSB      = 16;
    localparam int CAP_BYTE_HI  = 3;

    // Capabilities field positions.
    localparam int CAP_D3C_WAKE = 15;
    localparam int CAP_WAKE_HI  = 14;
    localparam int CAP_WAKE_LO  = 11;
    localparam int CAP_D2       = 10;
    localparam int CAP_D1       = 9;
    localparam int CAP_RSV_HI   = 8;
    localparam int CAP_RSV_LO   = 6;
    localparam int CAP_DSI      = 5;
    localparam int CAP_AUX      = 4;
    localparam int CAP_CLK      = 3;
    localparam int CAP_VER_HI   = 2;
    localparam int CAP_VER_LO   = 0;

    // Capabilities field values.
    localparam logic [3:0] CAP_WAKE_STATES = 4'hf;
    localparam logic       CAP_D2_VAL      = 1'b1;
    localparam logic       CAP_D1_VAL      = 1'b1;
    localparam logic [2:0] CAP_RSV_VAL     = 3'h0;
    localparam logic       CAP_DSI_VAL     = 1'b0;
    localparam logic       CAP_AUX_VAL     = 1'b0;
    localparam logic [2:0] CAP_VERSION     = 3'h2;
    localparam logic       CAP_D3C_RESET   = 1'b1;

    // Control/status field positions.
    localparam int CS_STATUS    = 15;
    localparam int CS_SCALE_HI  = 14;
    localparam int CS_SCALE_LO  = 13;
    localparam int CS_SEL_HI    = 12;
    localparam int CS_SEL_LO    = 9;
    localparam int CS_ENABLE    = 8;
    localparam int CS_RSV_HI    = 7;
    localparam int CS_RSV_LO    = 2;
    localparam int CS_STATE_HI  = 1;
    localparam int CS_STATE_LO  = 0;
    localparam int CS_BYTE_LO   = 0;
    localparam int CS_BYTE_HI   = 1;

    // Control/status field values.
    localparam logic [1:0] CS_SCALE_VAL = 2'h0;
    localparam logic [3:0] CS_SEL_VAL   = 4'h0;
    localparam logic [5:0] CS_RSV_VAL   = 6'h0;

    // Power state encodings.
    typedef enum logic [1:0] {
        PS_D0    = 2'b00,
        PS_D1    = 2'b01,
        PS_D2    = 2'b10,
        PS_D3HOT = 2'b11
    } power_state_e;

    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage
`default_nettype wire

// File: verilog/pm_wake_if.sv
// Signals between the register bank and its wake event unit.
`timescale 1ns/1ns
`default_nettype none
interface pm_wake_if;
    logic enable;
    logic status_clear;
    logic status;

    modport regs (
        output enable,
        output status_clear,
        input  status
    );
    modport unit (
        input  enable,
        input  status_clear,
        output status
    );
endinterface
`default_nettype wire

// File: verilog/wake_event_unit.sv
// Wake event status flag and wake event output.
`timescale 1ns/1ns
`default_nettype none
module wake_event_unit
    import pm_pkg::*;
(
    // Clock and resets.
    input  wire logic core_clk_i,
    input  wire logic rstn_i,
    input  wire logic bus_rstn_i,
    // Event source.
    input  wire logic wake_req_i,
    // Register side.
    pm_wake_if.unit   wake,
    // Wake event output.
    output logic      wake_event_o
);
    logic wake_event_status_q;

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            wake_event_status_q <= 1'b0;
        end else if (!bus_rstn_i && !wake.enable) begin
            wake_event_status_q <= 1'b0;
        end else if (wake_req_i) begin
            wake_event_status_q <= 1'b1;
        end else if (wake.status_clear) begin
            wake_event_status_q <= 1'b0;
        end
    end

    assign wake.status = wake_event_status_q;
    assign wake_event_o = wake_event_status_q && wake.enable;
endmodule
`default_nettype wire

// File: verilog/pci_power_mgmt_regs.sv
// Power management capabilities and control/status registers.
`timescale 1ns/1ns
`default_nettype none
module pci_power_mgmt_regs
    import pm_pkg::*;
#(
    parameter logic WAKE_NEEDS_CLK = 1'b0
)
(
    // Clock and resets.
    input  wire logic        core_clk_i,
    input  wire logic        rstn_i,
    input  wire logic        bus_rstn_i,
    // Configuration access.
    input  wire logic [7:0]  cfg_addr_i,
    input  wire logic        cfg_rd_i,
    input  wire logic        cfg_wr_i,
    input  wire logic [3:0]  cfg_be_i,
    input  wire logic [31:0] cfg_wdata_i,
    output logic      [31:0] cfg_rdata_o,
    output logic             cfg_rvalid_o,
    // Function events and state.
    input  wire logic        wake_req_i,
    output logic             wake_event_o,
    output logic      [1:0]  power_state_o,
    output logic             int_rst_o
);
    pm_wake_if wake ();

    logic        d3c_wake_q;
    logic        wake_event_enable_q;
    logic [1:0]  power_state_field_q;
    logic        int_rst_q;
    logic [31:0] rdata_q;
    logic        rvalid_q;
    logic [15:0] cap_word;
    logic [15:0] cs_word;
    logic        cap_hit;
    logic        cs_hit;
    logic        cs_state_wr;
    logic [1:0]  new_state;

    // Selects a dword address with the low address bits clear.
    function automatic logic dw_hit(input logic [7:0] a,
                                    input logic [7:0] base);
        dw_hit = (a[7:2] == base[7:2]) && (a[1:0] == ADDR_LSB_ZERO);
    endfunction

    assign cap_hit = dw_hit(cfg_addr_i, CAP_DW_ADDR);
    assign cs_hit  = dw_hit(cfg_addr_i, CTRL_DW_ADDR);

    // Capabilities word as read.
    always_comb begin
        cap_word = 16'h0000;
        cap_word[CAP_D3C_WAKE] = d3c_wake_q;
        cap_word[CAP_WAKE_HI:CAP_WAKE_LO] = CAP_WAKE_STATES;
        cap_word[CAP_D2] = CAP_D2_VAL;
        cap_word[CAP_D1] = CAP_D1_VAL;
        cap_word[CAP_RSV_HI:CAP_RSV_LO] = CAP_RSV_VAL;
        cap_word[CAP_DSI] = CAP_DSI_VAL;
        cap_word[CAP_AUX] = CAP_AUX_VAL && d3c_wake_q;
        cap_word[CAP_CLK] = WAKE_NEEDS_CLK
                            && (d3c_wake_q || (|CAP_WAKE_STATES));
        cap_word[CAP_VER_HI:CAP_VER_LO] = CAP_VERSION;
    end

    // Control/status word as read.
    always_comb begin
        cs_word = 16'h0000;
        cs_word[CS_STATUS] = wake.status;
        cs_word[CS_SCALE_HI:CS_SCALE_LO] = CS_SCALE_VAL;
        cs_word[CS_SEL_HI:CS_SEL_LO] = CS_SEL_VAL;
        cs_word[CS_ENABLE] = wake_event_enable_q;
        cs_word[CS_RSV_HI:CS_RSV_LO] = CS_RSV_VAL;
        cs_word[CS_STATE_HI:CS_STATE_LO] = power_state_field_q;
    end

    // Cold-D3 wake advertisement, cleared back to one by global reset only.
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            d3c_wake_q <= CAP_D3C_RESET;
        end else if (cfg_wr_i && cap_hit && cfg_be_i[CAP_BYTE_HI]) begin
            d3c_wake_q <= cfg_wdata_i[CAP_LSB + CAP_D3C_WAKE];
        end
    end

    // Wake enable ignores the bus reset.
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            wake_event_enable_q <= 1'b0;
        end else if (cfg_wr_i && cs_hit && cfg_be_i[CS_BYTE_HI]) begin
            wake_event_enable_q <= cfg_wdata_i[CS_ENABLE];
        end
    end

    // Wake status clear on a write of one; a zero leaves it alone.
    assign wake.enable = wake_event_enable_q;
    assign wake.status_clear = cfg_wr_i && cs_hit && cfg_be_i[CS_BYTE_HI]
                               && cfg_wdata_i[CS_STATUS];

    // Power state field, held through the internal reset.
    assign cs_state_wr = cfg_wr_i && cs_hit && cfg_be_i[CS_BYTE_LO];
    assign new_state   = cfg_wdata_i[CS_STATE_HI:CS_STATE_LO];

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i || !bus_rstn_i) begin
            power_state_field_q <= PS_D0;
        end else if (cs_state_wr) begin
            power_state_field_q <= new_state;
        end
    end

    // Internal reset pulse for the rest of the function.
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i || !bus_rstn_i) begin
            int_rst_q <= 1'b0;
        end else begin
            int_rst_q <= cs_state_wr && (power_state_field_q == PS_D3HOT)
                         && (new_state == PS_D0);
        end
    end

    // Registered read data; unmapped addresses read zero.
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            rdata_q  <= RDATA_ZERO;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= cfg_rd_i;
            if (cfg_rd_i) begin
                if (cap_hit) begin
                    rdata_q <= {cap_word, 16'h0000};
                end else if (cs_hit) begin
                    rdata_q <= {16'h0000, cs_word};
                end else begin
                    rdata_q <= RDATA_ZERO;
                end
            end
        end
    end

    wake_event_unit u_wake (
        .core_clk_i   (core_clk_i),
        .rstn_i       (rstn_i),
        .bus_rstn_i   (bus_rstn_i),
        .wake_req_i   (wake_req_i),
        .wake         (wake.unit),
        .wake_event_o (wake_event_o)
    );

    assign cfg_rdata_o   = rdata_q;
    assign cfg_rvalid_o  = rvalid_q;
    assign power_state_o = power_state_field_q;
    assign int_rst_o     = int_rst_q;
endmodule
`default_nettype wire

// File: verif/pm_host.sv
// Host model issuing configuration cycles and function wake requests.
`timescale 1ns/1ns
`default_nettype none
module pm_host (
    // Clock.
    input  wire logic        core_clk_i,
    // Configuration access.
    output logic      [7:0]  cfg_addr_o,
    output logic             cfg_rd_o,
    output logic             cfg_wr_o,
    output logic      [3:0]  cfg_be_o,
    output logic      [31:0] cfg_wdata_o,
    input  wire logic [31:0] cfg_rdata_i,
    input  wire logic        cfg_rvalid_i,
    // Wake request.
    output logic             wake_req_o
);
    initial begin
        {cfg_rd_o, cfg_wr_o, wake_req_o, cfg_be_o} = '0;
        {cfg_addr_o, cfg_wdata_o} = '0;
    end

    // Writes one dword; address and data lines then show the inverse of the last value, byte enables hold.
    task automatic wr(input logic [7:0] a, input logic [3:0] b,
                      input logic [31:0] d);
        @(negedge core_clk_i);
        {cfg_wr_o, cfg_addr_o, cfg_be_o, cfg_wdata_o} = {1'b1, a, b, d};
        @(negedge core_clk_i);
        {cfg_wr_o, cfg_addr_o, cfg_wdata_o} = {1'b0, ~a, ~d};
    endtask

    // Reads one dword; the answer is taken mid-cycle while it stands.
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic v);
        @(negedge core_clk_i);
        {cfg_rd_o, cfg_addr_o} = {1'b1, a};
        @(negedge core_clk_i);
        {v, d} = {cfg_rvalid_i, cfg_rdata_i};
        {cfg_rd_o, cfg_addr_o} = {1'b0, ~a};
    endtask

    // Raises the wake request for one cycle.
    task automatic wake();
        @(negedge core_clk_i);
        wake_req_o = 1'b1;
        @(negedge core_clk_i);
        wake_req_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// File: verif/pci_power_mgmt_regs_sva.sv
// Port assertions for the power management registers.
`timescale 1ns/1ns
`default_nettype none
module pm_regs_sva
    import pm_pkg::*;
#(
    parameter logic WAKE_NEEDS_CLK = 1'b0
)
(
    input wire logic        core_clk_i,
    input wire logic        rstn_i,
    input wire logic        bus_rstn_i,
    input wire logic [7:0]  cfg_addr_i,
    input wire logic        cfg_rd_i,
    input wire logic        cfg_wr_i,
    input wire logic [3:0]  cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic        cfg_rvalid_o,
    input wire logic        wake_req_i,
    input wire logic        wake_event_o,
    input wire logic [1:0]  power_state_o,
    input wire logic        int_rst_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    logic [7:0] rd_addr_q;
    logic [1:0] wd_q;
    always_ff @(posedge core_clk_i) begin
        if (cfg_rd_i) begin
            rd_addr_q <= cfg_addr_i;
        end
    end
    always_ff @(posedge core_clk_i) begin
        wd_q <= cfg_wdata_i[1:0];
    end
    wire logic cap_rd = cfg_rvalid_o && rd_addr_q == 8'ha0;
    wire logic cs_rd = cfg_rvalid_o && rd_addr_q == 8'ha4;
    wire logic cs_wr = cfg_wr_i && cfg_addr_i == 8'ha4 && bus_rstn_i;

    cap_d1_a: assert property (cap_rd |-> cfg_rdata_o[25])
        else $error("d1 bit low");
    cap_low_a: assert property (cap_rd |-> cfg_rdata_o[24:16] ==
        {5'h0, WAKE_NEEDS_CLK, 3'h2})
        else $error("cap low bits wrong");
    cs_zero_a: assert property (cs_rd |-> cfg_rdata_o[31:16] == 16'h0 &&
        cfg_rdata_o[14:9] == 6'h0 && cfg_rdata_o[7:2] == 6'h0)
        else $error("status zero bits set");
    state_wr_a: assert property (cs_wr && cfg_be_i[0] |=>
        power_state_o == wd_q)
        else $error("state not written");
    d3_exit_a: assert property (cs_wr && cfg_be_i[0] && power_state_o == 2'h3
        && cfg_wdata_i[1:0] == 2'h0 |=> int_rst_o ##1 !int_rst_o)
        else $error("no internal reset pulse");
    wake_gate_a: assert property (cs_wr && cfg_be_i[1] && !cfg_wdata_i[8]
        |=> !wake_event_o)
        else $error("wake without enable");
    wake_clr_a: assert property (cs_wr && cfg_be_i[1] && cfg_wdata_i[15] &&
        !wake_req_i |=> !wake_event_o)
        else $error("wake not cleared");
    bus_keep_a: assert property (wake_event_o && bus_rstn_i && !cfg_wr_i
        ##1 !bus_rstn_i && !cfg_wr_i
        ##1 bus_rstn_i |-> wake_event_o)
        else $error("bus reset lost wake");
    glob_rst_a: assert property (disable iff (1'b0) !rstn_i |=>
        !wake_event_o && power_state_o == 2'h0)
        else $error("reset left outputs");
    cover property (int_rst_o);
    cover property (wake_event_o ##1 !bus_rstn_i);
    cover property (cap_rd);
endmodule
bind pci_power_mgmt_regs pm_regs_sva #(.WAKE_NEEDS_CLK(WAKE_NEEDS_CLK))
    i_pm_regs_sva (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .bus_rstn_i(bus_rstn_i), .cfg_addr_i(cfg_addr_i), .cfg_rd_i(cfg_rd_i),
    .cfg_wr_i(cfg_wr_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
    .wake_req_i(wake_req_i), .wake_event_o(wake_event_o),
    .power_state_o(power_state_o), .int_rst_o(int_rst_o));
`default_nettype wire

// File: verif/pci_power_mgmt_regs_test.sv
// Self-checking bench for the power management registers.
`timescale 1ns/1ns
`default_nettype none
module pci_power_mgmt_regs_test;
    typedef struct {
        logic [7:0]  a;
        logic [3:0]  be;
        logic [31:0] d;
        logic [31:0] e;
    } row_s;
    logic        core_clk, rstn, bus_rstn, rd, wr, wreq, rv, wev, irst;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata, rdata, got;
    logic [1:0]  pst;
    int          fail_count = 0;
    int          samples_checked = 0;
    row_s rows [7] = '{
        '{8'ha0, 4'h0, 32'h0, 32'hfe02_0000},
        '{8'ha4, 4'hf, 32'hffff_fffe, 32'h0000_0102},
        '{8'ha4, 4'h1, 32'h0000_0001, 32'h0000_0101},
        '{8'ha0, 4'hf, 32'h0, 32'h7e02_0000},
        '{8'ha8, 4'hf, 32'hffff_ffff, 32'h0},
        '{8'ha5, 4'hf, 32'hffff_ffff, 32'h0},
        '{8'ha0, 4'h7, 32'hffff_ffff, 32'h7e02_0000}
    };

    pci_power_mgmt_regs i_pci_power_mgmt_regs (.core_clk_i(core_clk),
        .rstn_i(rstn), .bus_rstn_i(bus_rstn), .cfg_addr_i(addr),
        .cfg_rd_i(rd), .cfg_wr_i(wr), .cfg_be_i(be), .cfg_wdata_i(wdata),
        .cfg_rdata_o(rdata), .cfg_rvalid_o(rv), .wake_req_i(wreq),
        .wake_event_o(wev), .power_state_o(pst), .int_rst_o(irst));
    pm_host i_pm_host (.core_clk_i(core_clk), .cfg_addr_o(addr),
        .cfg_rd_o(rd), .cfg_wr_o(wr), .cfg_be_o(be), .cfg_wdata_o(wdata),
        .cfg_rdata_i(rdata), .cfg_rvalid_i(rv), .wake_req_o(wreq));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("Error %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic v;
        i_pm_host.rd(a, got, v);
        chk({31'h0, v}, 32'h1);
        chk(got, e);
    endtask

    task automatic pulse(input logic glob);
        @(negedge core_clk);
        {rstn, bus_rstn} = glob ? 2'b01 : 2'b10;
        @(negedge core_clk);
        {rstn, bus_rstn} = 2'b11;
    endtask

    task automatic end_of_test();
        $display("fail_count %0d samples_checked %0d", fail_count,
                 samples_checked);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #20000;
        fail_count++;
        end_of_test();
    end

    initial begin
        {rstn, bus_rstn} = 2'b01;
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        for (int i = 0; i < 7; i++) begin
            i_pm_host.wr(rows[i].a, rows[i].be, rows[i].d);
            rc(rows[i].a, rows[i].e);
        end
        i_pm_host.wr(8'ha4, 4'h1, 32'h3);
        chk({30'h0, pst}, 32'h3);
        i_pm_host.wr(8'ha4, 4'h1, 32'h0);
        chk({31'h0, irst}, 32'h1);
        @(negedge core_clk);
        chk({31'h0, irst}, 32'h0);
        rc(8'ha4, 32'h0000_0100);
        i_pm_host.wake();
        chk({31'h0, wev}, 32'h1);
        pulse(1'b0);
        chk({31'h0, wev}, 32'h1);
        rc(8'ha4, 32'h0000_8100);
        i_pm_host.wr(8'ha4, 4'h2, 32'h0000_8100);
        chk({31'h0, wev}, 32'h0);
        rc(8'ha4, 32'h0000_0100);
        i_pm_host.wr(8'ha4, 4'h2, 32'h0);
        i_pm_host.wake();
        chk({31'h0, wev}, 32'h0);
        rc(8'ha4, 32'h0000_8000);
        pulse(1'b0);
        rc(8'ha4, 32'h0);
        i_pm_host.wr(8'ha4, 4'h2, 32'h0000_0100);
        pulse(1'b1);
        rc(8'ha0, 32'hfe02_0000);
        rc(8'ha4, 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
